//--- include/port_pin_override_mux_defines.svh
`ifndef PORT_PIN_OVERRIDE_MUX_DEFINES_SVH
`define PORT_PIN_OVERRIDE_MUX_DEFINES_SVH

// Register byte offsets
`define OFS_PIN_IN   12'h000
`define OFS_DIR      12'h004
`define OFS_LATCH    12'h008
`define OFS_CTRL     12'h00c
`define OFS_STATUS   12'h010

// Control register fields
`define CTRL_PULLUP_DIS_BIT  0
`define CTRL_ASYNC_TMR_BIT   1
`define CTRL_EXT_CLK_BIT     2
`define CTRL_RST_VAL    3'h0

// Status register fields
`define STAT_CLK7_BIT   0
`define STAT_CLAMP_BIT  1

// Port register reset value
`define PORT_RST_VAL    8'h00

// Index of the oscillator pin
`define OSC_PIN_IDX     7

`endif

//--- include/port_pin_override_mux_pkg.sv
package port_pin_override_mux_pkg;

  // Processor sleep state, from the sleep controller
  typedef enum logic [2:0] {
    SLP_ACTIVE    = 3'b000,
    SLP_IDLE      = 3'b001,
    SLP_ADC_NR    = 3'b010,
    SLP_PDOWN     = 3'b011,
    SLP_PSAVE     = 3'b100,
    SLP_STANDBY   = 3'b110,
    SLP_EXT_STDBY = 3'b111
  } sleep_mode_t;

  // Decoded register selection
  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_PIN    = 3'b001,
    SEL_DIR    = 3'b010,
    SEL_LATCH  = 3'b011,
    SEL_CTRL   = 3'b100,
    SEL_STATUS = 3'b101
  } reg_sel_t;

endpackage

//--- verilog/pin_sync3.sv
// Three-stage pad synchroniser; output moves once stages two and three agree
module pin_sync3 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Asynchronous pad levels
  input  wire logic [WIDTH-1:0] async_in,
  // Filtered synchronous levels
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] st1_ff;   // Metastability catcher, read by st2 only
  logic [WIDTH-1:0] st2_ff;   // Second stage
  logic [WIDTH-1:0] st3_ff;   // Third stage
  logic [WIDTH-1:0] out_ff;   // Accepted level

  // Shift chain
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st1_ff <= '0;
      st2_ff <= '0;
      st3_ff <= '0;
    end else begin
      st1_ff <= async_in;
      st2_ff <= st1_ff;
      st3_ff <= st2_ff;
    end
  end

  // Accept a level only when the last two stages agree
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_ff <= '0;
    end else begin
      out_ff <= (st2_ff & st3_ff) | (out_ff & (st2_ff | st3_ff));
    end
  end

  assign sync_out = out_ff;

endmodule

//--- verilog/port_pin_override_mux.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`include "port_pin_override_mux_defines.svh"

module port_pin_override_mux #(
  parameter int NPINS = 8
) (
  // Clock and reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  sys_rst,
  // APB slave
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [11:0]                           paddr,
  input  wire logic [31:0]                           pwdata,
  output logic      [31:0]                           prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // Global state from sleep and clock systems
  input  wire port_pin_override_mux_pkg::sleep_mode_t sleep_mode,
  input  wire logic                                  main_osc_on_pin7,
  input  wire logic [NPINS-1:0]                      ext_irq_en,
  // Per-pin overrides from peripheral modules
  input  wire logic [NPINS-1:0]                      pullup_override_en,
  input  wire logic [NPINS-1:0]                      pullup_override_val,
  input  wire logic [NPINS-1:0]                      dir_override_en,
  input  wire logic [NPINS-1:0]                      dir_override_val,
  input  wire logic [NPINS-1:0]                      value_override_en,
  input  wire logic [NPINS-1:0]                      value_override_val,
  input  wire logic [NPINS-1:0]                      toggle_override_en,
  input  wire logic [NPINS-1:0]                      input_en_override_en,
  input  wire logic [NPINS-1:0]                      input_en_override_val,
  // Signals handed to peripheral modules
  output logic      [NPINS-1:0]                      raw_digital_input,
  output logic      [NPINS-1:0]                      pin_change_src,
  // Analog path, both directions
  input  wire logic [NPINS-1:0]                      analog_pad_path_oe,
  input  wire logic [NPINS-1:0]                      analog_pad_path_out,
  output logic      [NPINS-1:0]                      analog_pad_path_in,
  // Pads
  input  wire logic [NPINS-1:0]                      pad_in,
  output logic      [NPINS-1:0]                      pad_out,
  output logic      [NPINS-1:0]                      pad_oe,
  output logic      [NPINS-1:0]                      pad_pullup_en
);

  import port_pin_override_mux_pkg::*;

  // Bit seven logic and the 32-bit data bus bound the width
  if (NPINS < 8 || NPINS > 32) begin : g_bad_width
    $error("NPINS must lie in 8..32");
  end

  localparam int OSC = `OSC_PIN_IDX;

  logic [NPINS-1:0] dir_ff;        // Direction bits
  logic [NPINS-1:0] latch_ff;      // Output latch bits
  logic [2:0]       ctrl_ff;       // Pull-up disable, async select, ext clock
  logic [31:0]      rdata_ff;      // Read data captured in setup phase
  logic [NPINS-1:0] pin_sync;      // Synchronised pin levels
  logic [NPINS-1:0] drv_en;        // Output driver enables
  logic [NPINS-1:0] din_en;        // Digital input buffer enables
  logic [NPINS-1:0] pu_en;         // Pull-up enables before reset gating
  logic [NPINS-1:0] nxt_latch;     // Next latch value
  logic             wr_access;     // Write completes this edge
  logic             rd_setup;      // Read setup cycle
  logic             pullup_dis;    // Global pull-up disable
  logic             clk7;          // Bit seven serves as clock pin
  logic             deep_sleep;    // Sleep state that clamps inputs
  reg_sel_t         sel;           // Decoded register

  // Address decode, used by read capture, writes and error answer
  function automatic reg_sel_t decode(input logic [11:0] addr);
    unique case (addr)
      `OFS_PIN_IN: decode = SEL_PIN;
      `OFS_DIR:    decode = SEL_DIR;
      `OFS_LATCH:  decode = SEL_LATCH;
      `OFS_CTRL:   decode = SEL_CTRL;
      `OFS_STATUS: decode = SEL_STATUS;
      default:     decode = SEL_NONE;
    endcase
  endfunction

  // One decode serves every pin of the port
  assign sel       = decode(paddr);
  assign wr_access = psel & penable & pwrite;
  assign rd_setup  = psel & ~penable & ~pwrite;

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (sel == SEL_NONE);
  assign prdata  = rdata_ff;

  // Shared global controls
  assign pullup_dis = ctrl_ff[`CTRL_PULLUP_DIS_BIT];

  // Crystal on bit seven, timer or main oscillator
  assign clk7 = (ctrl_ff[`CTRL_ASYNC_TMR_BIT] & ~ctrl_ff[`CTRL_EXT_CLK_BIT])
              | main_osc_on_pin7;

  // Deep sleep states that clamp floating inputs
  assign deep_sleep = (sleep_mode == SLP_PDOWN) | (sleep_mode == SLP_PSAVE)
                    | (sleep_mode == SLP_STANDBY);

  // Control register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_ff <= `CTRL_RST_VAL;
    end else if (wr_access && sel == SEL_CTRL) begin
      ctrl_ff <= pwdata[2:0];
    end
  end

  // Direction register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_ff <= NPINS'(`PORT_RST_VAL);
    end else if (wr_access && sel == SEL_DIR) begin
      dir_ff <= pwdata[NPINS-1:0];
    end
  end

  // Latch next value: write, pin-register toggle, module toggle
  always_comb begin
    nxt_latch = latch_ff;
    if (wr_access && sel == SEL_LATCH) begin
      nxt_latch = pwdata[NPINS-1:0];
    end else if (wr_access && sel == SEL_PIN) begin
      nxt_latch = latch_ff ^ pwdata[NPINS-1:0];
    end
    // A module toggle on top of a software toggle flips twice
    nxt_latch = nxt_latch ^ toggle_override_en;
  end

  // Output latch register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      latch_ff <= NPINS'(`PORT_RST_VAL);
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  // Read data captured during setup so it comes from a flip-flop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (rd_setup) begin
      rdata_ff <= '0;
      unique case (sel)
        // Bit seven reads zero while it is a clock pin
        SEL_PIN: begin
          rdata_ff[NPINS-1:0] <= pin_sync;
          rdata_ff[OSC]       <= pin_sync[OSC] & ~clk7;
        end
        SEL_DIR: begin
          rdata_ff[NPINS-1:0] <= dir_ff;
          rdata_ff[OSC]       <= dir_ff[OSC] & ~clk7;
        end
        SEL_LATCH: begin
          rdata_ff[NPINS-1:0] <= latch_ff;
          rdata_ff[OSC]       <= latch_ff[OSC] & ~clk7;
        end
        SEL_CTRL: begin
          rdata_ff[2:0] <= ctrl_ff;
        end
        SEL_STATUS: begin
          rdata_ff[`STAT_CLK7_BIT]  <= clk7;
          rdata_ff[`STAT_CLAMP_BIT] <= deep_sleep;
        end
        SEL_NONE: begin
          rdata_ff <= '0;
        end
      endcase
    end
  end

  // Per-pin override muxes
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    logic pu_ovr_en;    // Effective pull-up override enable
    logic pu_ovr_val;   // Effective pull-up override value
    logic drv_ovr_en;   // Effective direction override enable
    logic drv_ovr_val;  // Effective direction override value
    logic in_ovr_en;    // Effective input-enable override enable
    logic in_ovr_val;   // Effective input-enable override value
    logic clkp;         // This pin is the detached clock pin

    // Idle modules tie enables low, leaving plain I/O
    assign clkp        = (i == OSC) ? clk7 : 1'b0;
    // Clock pin: pull-up, driver and input all forced off
    assign pu_ovr_en   = pullup_override_en[i] | clkp;
    assign pu_ovr_val  = pullup_override_val[i] & ~clkp;
    assign drv_ovr_en  = dir_override_en[i] | clkp;
    assign drv_ovr_val = dir_override_val[i] & ~clkp;
    assign in_ovr_en   = input_en_override_en[i] | clkp;
    assign in_ovr_val  = input_en_override_val[i] & ~clkp;

    // Pull-up select
    assign pu_en[i] = pu_ovr_en ? pu_ovr_val : (~dir_ff[i] & latch_ff[i] & ~pullup_dis);

    // Driver enable select
    assign drv_en[i] = drv_ovr_en ? drv_ovr_val : dir_ff[i];

    // Input enable: override, else clamp unless interrupt keeps it
    assign din_en[i] = in_ovr_en ? in_ovr_val
                                 : ~(deep_sleep & ~ext_irq_en[i]);

    // Pad drive; analog path takes the pad straight
    assign pad_oe[i]  = ~sys_rst & (analog_pad_path_oe[i] | drv_en[i]);
    assign pad_out[i] = analog_pad_path_oe[i] ? analog_pad_path_out[i]
                      : (value_override_en[i] ? value_override_val[i]
                                              : latch_ff[i]);
  end

  // Pull-ups released while reset holds the pins tri-stated
  assign pad_pullup_en = pu_en & {NPINS{~sys_rst}};

  // Analog pad level, no digital logic in between
  assign analog_pad_path_in = pad_in;

  // Buffered, clamped, unsynchronised input for modules
  assign raw_digital_input = pad_in & din_en;

  // Port's own synchroniser for the pin register
  pin_sync3 #(
    .WIDTH    (NPINS)
  ) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (raw_digital_input),
    .sync_out (pin_sync)
  );

  // Each bit, seven among them, feeds pin-change logic
  assign pin_change_src = raw_digital_input;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_pin_toggle_write;
    psel && penable && pwrite && sel == SEL_PIN && pwdata[0]
      && !toggle_override_en[0];
  endsequence

  sequence s_dir_read_clk7;
    rd_setup && sel == SEL_DIR && clk7;
  endsequence

  a_pullup_override: assert property (
    pullup_override_en[0] |-> pad_pullup_en[0] == pullup_override_val[0])
    else $error("pull-up ignores override value");

  a_pullup_plain: assert property (
    !pullup_override_en[0]
      |-> pad_pullup_en[0] == (!dir_ff[0] && latch_ff[0] && !pullup_dis))
    else $error("plain pull-up wrong");

  a_driver_select: assert property (
    !analog_pad_path_oe[0]
      |-> pad_oe[0] == (dir_override_en[0] ? dir_override_val[0] : dir_ff[0]))
    else $error("driver enable wrong");

  a_value_select: assert property (
    pad_oe[0] && !analog_pad_path_oe[0]
      |-> pad_out[0] == (value_override_en[0] ? value_override_val[0]
                                              : latch_ff[0]))
    else $error("driven level wrong");

  a_toggle_module: assert property (
    toggle_override_en[1] && !wr_access
      |=> latch_ff[1] != $past(latch_ff[1]))
    else $error("module toggle lost");

  a_pin_write_toggle: assert property (
    s_pin_toggle_write |=> latch_ff[0] != $past(latch_ff[0]))
    else $error("pin write did not toggle latch");

  a_input_clamp: assert property (
    deep_sleep && !input_en_override_en[0] && !ext_irq_en[0]
      |-> !raw_digital_input[0] && pin_change_src[0] == 1'b0)
    else $error("deep sleep did not clamp input");

  a_clock_pin_off: assert property (
    clk7 && !analog_pad_path_oe[OSC]
      |-> !pad_oe[OSC] && !pad_pullup_en[OSC] && !raw_digital_input[OSC])
    else $error("clock pin still used as I/O");

  a_clock_pin_read: assert property (
    s_dir_read_clk7 ##1 psel && penable |-> prdata[OSC] == 1'b0)
    else $error("clock pin direction bit not zero");

  a_pin_sync_delay: assert property (
    $rose(raw_digital_input[0]) ##1 raw_digital_input[0] [*3]
      |=> pin_sync[0])
    else $error("pin register did not follow input");

  // Status read: setup, then the access that shows the captured word
  sequence s_status_read;
    rd_setup && sel == SEL_STATUS ##1 psel && penable;
  endsequence

  // A module toggle in the write cycle flips the freshly written bits
  a_latch_write: assert property (
    wr_access && sel == SEL_LATCH
      |=> latch_ff == (NPINS'($past(pwdata)) ^ $past(toggle_override_en)))
    else $error("latch write or module toggle lost");

  a_dir_write: assert property (
    wr_access && sel == SEL_DIR |=> dir_ff == NPINS'($past(pwdata)))
    else $error("direction write lost");

  a_status_clamp: assert property (
    s_status_read |-> prdata[`STAT_CLAMP_BIT] == $past(deep_sleep))
    else $error("status clamp bit wrong");

  // Analog drive beats every digital override on the pad
  a_analog_drive: assert property (
    analog_pad_path_oe[0] |-> pad_oe[0] && pad_out[0] == analog_pad_path_out[0])
    else $error("analog path does not own the pad");

endmodule

//--- bench/periph_override_model.sv
// Peripheral side: produces per-pin override signals on request
module periph_override_model (
  // Clock
  input  wire logic            clk_sys,
  // Pins that some peripheral owns
  input  wire logic [7:0]      owner,
  // Requested pattern, one byte per override signal
  input  wire logic [8:0][7:0] req,
  // Override signals toward the port
  output logic      [8:0][7:0] ovr
);
  timeunit 1ns;
  timeprecision 1ps;

  // Launched just after the edge like real logic
  // Enables only where a peripheral owns the pin; plain I/O elsewhere
  always_ff @(posedge clk_sys) begin
    for (int k = 0; k < 9; k++) begin
      ovr[k] <= (k inside {0, 2, 4, 6, 7}) ? (req[k] & owner) : req[k];
    end
  end
endmodule

//--- bench/port_pin_override_mux_tb.sv
`include "port_pin_override_mux_defines.svh"

module port_pin_override_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import port_pin_override_mux_pkg::*;

  // Clock, reset, APB
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  // Global state and pads
  sleep_mode_t sleep_mode;
  logic        main_osc_on_pin7;
  logic [7:0]  ext_irq_en, owner, pad_in, pad_out, pad_oe, pad_pullup_en;
  logic [7:0]  analog_pad_path_oe, analog_pad_path_out, analog_pad_path_in;
  logic [7:0]  raw_digital_input, pin_change_src;
  // Override request and result
  logic [8:0][7:0] req, ovr;
  // Bench copy of register contents
  logic [7:0]  dir_s, lat_s;
  logic [2:0]  ctl_s;
  int          num_errors, samples_checked, cyc;
  sleep_mode_t modes[7] = '{SLP_ACTIVE, SLP_IDLE, SLP_ADC_NR, SLP_PDOWN, SLP_PSAVE,
                            SLP_STANDBY, SLP_EXT_STDBY};

  // Block under test
  port_pin_override_mux dut_u (
    .clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sleep_mode, .main_osc_on_pin7, .ext_irq_en,
    .pullup_override_en(ovr[0]), .pullup_override_val(ovr[1]),
    .dir_override_en(ovr[2]), .dir_override_val(ovr[3]),
    .value_override_en(ovr[4]), .value_override_val(ovr[5]),
    .toggle_override_en(ovr[6]), .input_en_override_en(ovr[7]),
    .input_en_override_val(ovr[8]), .raw_digital_input, .pin_change_src,
    .analog_pad_path_oe, .analog_pad_path_out, .analog_pad_path_in,
    .pad_in, .pad_out, .pad_oe, .pad_pullup_en
  );

  // Peripheral model
  periph_override_model peri_u (.clk_sys, .owner, .req, .ovr);

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Hang guard, far above the expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      give_verdict();
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready with no assumed latency
  task automatic apb(input int w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w[0];
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bit 7 taken by an oscillator
  function automatic logic [7:0] clkpin();
    return {(ctl_s[1] & ~ctl_s[2]) | main_osc_on_pin7, 7'h00};
  endfunction

  // Deep sleep clamps inputs
  function automatic logic deep();
    return sleep_mode inside {SLP_PDOWN, SLP_PSAVE, SLP_STANDBY};
  endfunction

  // Pad-side expectations from bench state
  task automatic check_pins();
    logic [7:0] cp, drv, val, pue, ie, dg;
    cp = clkpin();
    drv = ((ovr[2] & ovr[3]) | (~ovr[2] & dir_s)) & ~cp;
    // Digitally driven pins only; analog drive owns the rest
    dg = drv & ~analog_pad_path_oe;
    val = (ovr[4] & ovr[5]) | (~ovr[4] & lat_s);
    pue = ((ovr[0] & ovr[1]) | (~ovr[0] & ~dir_s & lat_s & {8{~ctl_s[0]}})) & ~cp;
    ie = ((ovr[7] & ovr[8]) | (~ovr[7] & ~({8{deep()}} & ~ext_irq_en))) & ~cp;
    chk(pad_oe, drv | analog_pad_path_oe);
    chk(pad_out & dg, val & dg);
    chk(pad_out & analog_pad_path_oe, analog_pad_path_out & analog_pad_path_oe);
    chk(pad_pullup_en, pue);
    chk(raw_digital_input, pad_in & ie);
    chk(pin_change_src, pad_in & ie);
    chk(analog_pad_path_in, pad_in);
  endtask

  // Closing report
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial begin
    {sys_rst, psel, penable, pwrite, main_osc_on_pin7} = 5'h10;
    {paddr, pwdata, ext_irq_en, pad_in, analog_pad_path_oe, analog_pad_path_out} = '0;
    sleep_mode = SLP_ACTIVE;
    owner = 8'hff;
    // Overrides up during reset, toggle kept low
    req = 72'hff_ff_00_ff_ff_ff_ff_ff_ff;
    {dir_s, lat_s, ctl_s} = '0;
    void'($urandom(59));
    @(posedge clk_sys);
    #1;
    chk(pad_oe, 8'h00);
    chk(pad_pullup_en, 8'h00);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    req <= '0;
    // Reset values, then an unmapped place
    apb(0, `OFS_DIR, 0);
    chk(q, 0);
    apb(0, `OFS_LATCH, 0);
    chk(q, 0);
    apb(0, `OFS_CTRL, 0);
    chk(q, 0);
    apb(1, 12'h014, '1);
    chk(e, 1);
    apb(0, 12'h014, 0);
    chk(q, 0);
    chk(e, 1);
    $display("reset test done");
    // Bit 7 as oscillator pin with timer crystal and with main crystal; the external clock setting leaves it plain I/O
    for (int k = 0; k < 3; k++) begin
      ctl_s = (k == 0) ? 3'h2 : (k == 1) ? 3'h6 : 3'h0;
      main_osc_on_pin7 <= (k == 2);
      pad_in <= 8'hff;
      {dir_s, lat_s} = 16'hffff;
      apb(1, `OFS_CTRL, 32'(ctl_s));
      apb(1, `OFS_DIR, 32'hff);
      apb(1, `OFS_LATCH, 32'hff);
      repeat (5) @(posedge clk_sys);
      #1;
      check_pins();
      apb(0, `OFS_DIR, 0);
      chk(q, dir_s & ~clkpin());
      apb(0, `OFS_LATCH, 0);
      chk(q, lat_s & ~clkpin());
      apb(0, `OFS_PIN_IN, 0);
      chk(q, 8'hff & ~clkpin());
      apb(0, `OFS_STATUS, 0);
      chk(q, 32'(clkpin() >> 7));
    end
    $display("clock pin test done");
    // Peripheral toggle, then software toggle via the pin register
    ctl_s = 3'h0;
    main_osc_on_pin7 <= 1'b0;
    apb(1, `OFS_CTRL, 0);
    req[6] <= 8'h5a;
    @(posedge clk_sys);
    req[6] <= 8'h00;
    repeat (3) @(posedge clk_sys);
    apb(0, `OFS_LATCH, 0);
    chk(q, 32'(lat_s ^ 8'h5a));
    lat_s = lat_s ^ 8'h5a ^ 8'hc3;
    apb(1, `OFS_PIN_IN, 32'hc3);
    apb(0, `OFS_LATCH, 0);
    chk(q, 32'(lat_s));
    $display("toggle test done");
    // Raw input ahead of the synchroniser
    pad_in <= 8'h00;
    repeat (6) @(posedge clk_sys);
    pad_in <= 8'h3c;
    #1;
    chk(raw_digital_input, 8'h3c);
    apb(0, `OFS_PIN_IN, 0);
    chk(q, 0);
    repeat (4) @(posedge clk_sys);
    apb(0, `OFS_PIN_IN, 0);
    chk(q, 32'h3c);
    $display("input path test done");
    // Random mix of registers, overrides, sleep state and pads
    for (int n = 0; n < 60; n++) begin
      dir_s = 8'($urandom);
      lat_s = 8'($urandom);
      ctl_s = 3'($urandom);
      apb(1, `OFS_DIR, 32'(dir_s));
      apb(1, `OFS_LATCH, 32'(lat_s));
      apb(1, `OFS_CTRL, 32'(ctl_s));
      owner <= (n == 0) ? 8'h00 : 8'($urandom);
      ext_irq_en <= 8'($urandom);
      analog_pad_path_oe <= 8'($urandom) & 8'h7f;
      analog_pad_path_out <= 8'($urandom);
      pad_in <= 8'($urandom);
      main_osc_on_pin7 <= ($urandom % 8 == 0);
      sleep_mode <= modes[$urandom % 7];
      for (int k = 0; k < 9; k++) req[k] <= (k == 6) ? 8'h00 : 8'($urandom);
      repeat (2) @(posedge clk_sys);
      #1;
      check_pins();
      apb(0, `OFS_STATUS, 0);
      chk(q, {30'h0, deep(), 1'(clkpin() >> 7)});
    end
    $display("random test done");
    give_verdict();
  end
endmodule
